/* hdl/drct_pkg.sv */
package drct_pkg;
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned ADDR_W         = 11;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned ROWS           = 1024;
  localparam int unsigned COLS           = 2048;
  localparam int unsigned INIT_CYCLES    = 8;
  localparam int unsigned POWERUP_US     = 200;
  localparam int unsigned POWERUP_CYC    = POWERUP_US * CLK_MHZ;
  localparam int unsigned REFRESH_MS_STD = 16;
  localparam int unsigned REFRESH_MS_LP  = 128;
  localparam int unsigned ROW_INTV_STD   = (REFRESH_MS_STD * 1000 * CLK_MHZ) / ROWS;
  localparam int unsigned ROW_ACTIVE_US  = 10;
  localparam int unsigned ROW_ACTIVE_CYC = ROW_ACTIVE_US * CLK_MHZ;
  localparam int unsigned PH_NS          = 80;
  localparam int unsigned PH_CYC         = (PH_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  PH_CYC_W       = 8'(PH_CYC);

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_PWRUP   = 4'h1,
    ST_INIT    = 4'h3,
    ST_FILL    = 4'h2,
    ST_CNTREAD = 4'h6,
    ST_CNTWR   = 4'h7,
    ST_CHECK   = 4'h5,
    ST_DONE    = 4'h4,
    ST_REFR    = 4'h8
  } drct_state_e;

  typedef enum logic [2:0] {
    CY_NORMAL_WR = 3'h0,
    CY_NORMAL_RD = 3'h1,
    CY_CBR       = 3'h2,
    CY_CBR_RD    = 3'h3,
    CY_CBR_WR    = 3'h4
  } drct_cycle_e;
endpackage

/* hdl/drct_strobe_gen.sv */
`timescale 1ns/1ps
// One memory cycle on the strobes; phase lengths fixed at PH_CYC + 1 clocks.
module drct_strobe_gen
  import drct_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clockEnable,
  input  wire logic              start,
  input  wire logic [2:0]        cycleKind,
  input  wire logic [ADDR_W-1:0] rowAddr,
  input  wire logic [ADDR_W-1:0] colAddr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic [DATA_W-1:0] dataLinesIn,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      rdData,
  output logic                   rowStrobe_n,
  output logic                   colStrobe_n,
  output logic                   writeStrobe_n,
  output logic [ADDR_W-1:0]      addressInputs,
  output logic [DATA_W-1:0]      dataLinesOut,
  output logic                   dataLinesOe_n
);
  logic [2:0] phase_reg;
  logic [7:0] tick_reg;
  logic [2:0] kind_reg;
  logic       cbr;
  logic       isWr;
  assign cbr  = (kind_reg == CY_CBR) || (kind_reg == CY_CBR_RD) || (kind_reg == CY_CBR_WR);
  assign isWr = (kind_reg == CY_NORMAL_WR) || (kind_reg == CY_CBR_WR);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg     <= 3'h0;
      tick_reg      <= 8'h00;
      kind_reg      <= 3'h0;
      busy          <= 1'b0;
      done          <= 1'b0;
      rdData        <= 8'h00;
      rowStrobe_n   <= 1'b1;
      colStrobe_n   <= 1'b1;
      writeStrobe_n <= 1'b1;
      addressInputs <= 11'h000;
      dataLinesOut  <= 8'h00;
      dataLinesOe_n <= 1'b1;
    end else if (clockEnable) begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy      <= 1'b1;
          kind_reg  <= cycleKind;
          phase_reg <= 3'h1;
          tick_reg  <= PH_CYC_W;
          addressInputs <= rowAddr;
          dataLinesOut  <= wrData;
        end
      end else if (tick_reg != 8'h00) begin
        tick_reg <= tick_reg - 8'h01;
      end else begin
        tick_reg  <= PH_CYC_W;
        phase_reg <= phase_reg + 3'h1;
        case (phase_reg)
          3'h1: begin
            // Write level set on the same edge as the first strobe falls
            writeStrobe_n <= ~isWr;
            dataLinesOe_n <= ~isWr;
            if (cbr) colStrobe_n <= 1'b0;
            else rowStrobe_n <= 1'b0;
          end
          3'h2: begin
            addressInputs <= colAddr; // Row plus column fields pick one byte
            if (cbr) rowStrobe_n <= 1'b0;
          end
          3'h3: begin
            // Counter-test cycle: CAS cycled after RAS with column address
            if (kind_reg == CY_CBR_RD || kind_reg == CY_CBR_WR) colStrobe_n <= 1'b1;
            else colStrobe_n <= 1'b0;
          end
          3'h4: colStrobe_n <= 1'b0;
          3'h5: begin
            // Data is unlatched: sample while the column strobe is low
            rdData        <= dataLinesIn;
            rowStrobe_n   <= 1'b1;
            colStrobe_n   <= 1'b1;
            writeStrobe_n <= 1'b1;
            dataLinesOe_n <= 1'b1;
          end
          default: begin
            busy      <= 1'b0;
            done      <= 1'b1;
            phase_reg <= 3'h0;
          end
        endcase
      end
    end
  end

  // Row strobe held well under its active limit by the fixed phases
  rowlimit_a: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(rowStrobe_n) |-> ##[1:200] rowStrobe_n)
    else $error("row strobe held too long");
  cbrorder_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($fell(rowStrobe_n) && cbr) |-> !colStrobe_n)
    else $error("column strobe not first in refresh");
  wrlevel_a: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(colStrobe_n) |-> (writeStrobe_n == !isWr))
    else $error("write level wrong at column strobe");
endmodule

/* hdl/drct_refresh_tester.sv */
`timescale 1ns/1ps
// Operation
// - Counter-test cycles are read-write; write strobe level picks the phase.
// - At least 8 column-first refresh cycles precede the test.
// - Step one writes the first pattern to every cell with normal writes.
// - Step two: fixed column, 1024 counter reads expecting the pattern.
// - Step three: fixed column, 1024 counter writes of the complement.
// - Step four: normal reads check the complement in the test column.
// - Whole sequence repeats with inverted data.
// - All 1024 rows refreshed within 16 ms, or 128 ms low-power.
// - Row strobe active no longer than 10 us.
// - Column strobe before row strobe selects counter refresh.
// - After power-up wait 200 us, then 8 row strobe cycles.
// - Low write strobe writes; high before column strobe reads.
module drct_refresh_tester
  import drct_pkg::*;
#(
  parameter int unsigned POWERUP_WAIT = POWERUP_CYC,
  parameter int unsigned ROW_INTERVAL = ROW_INTV_STD,
  parameter int unsigned FILL_ROWS    = ROWS,
  parameter int unsigned FILL_COLS    = COLS,
  parameter int unsigned TEST_ROWS    = ROWS
)(
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              clockEnable,
  input  wire logic              testStart,
  input  wire logic [ADDR_W-1:0] testColumn,
  input  wire logic [DATA_W-1:0] dataLinesIn,
  output logic                   rowStrobe_n,
  output logic                   colStrobe_n,
  output logic                   writeStrobe_n,
  output logic [ADDR_W-1:0]      addressInputs,
  output logic [DATA_W-1:0]      dataLinesOut,
  output logic                   dataLinesOe_n,
  output logic                   ready,
  output logic                   testBusy,
  output logic                   testDone,
  output logic                   testFail,
  output logic [ADDR_W-1:0]      failRow,
  output logic [ADDR_W-1:0]      failCol
);
  logic [1:0]        rstSync_reg;
  logic              rst_n;
  drct_state_e       retState_reg;
  logic [DATA_W-1:0] dinS1_reg;
  logic [DATA_W-1:0] dinS2_reg;
  drct_state_e       state_reg;
  logic [31:0]       wait_reg;
  logic [31:0]       refTimer_reg;
  logic              refDue_reg;
  logic [ADDR_W-1:0] row_reg;
  logic [ADDR_W-1:0] col_reg;
  logic [ADDR_W-1:0] testCol_reg;
  logic [DATA_W-1:0] pattern_reg;
  logic              pass_reg;
  logic [10:0]       count_reg;
  logic              start_reg;
  logic [2:0]        kind_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic              busy;
  logic              cycDone;
  logic [DATA_W-1:0] rdData;
  logic              cycPending_reg;
  logic              checkRead_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rstSync_reg <= 2'h0;
    else rstSync_reg <= {rstSync_reg[0], 1'b1};
  end
  assign rst_n = rstSync_reg[1];

  // Data pins are asynchronous to our clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dinS1_reg <= 8'h00;
      dinS2_reg <= 8'h00;
    end else if (clockEnable) begin
      dinS1_reg <= dataLinesIn;
      dinS2_reg <= dinS1_reg;
    end
  end

  // Distributed refresh: one row per interval keeps 1024 rows inside 16 ms
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      refTimer_reg <= 32'h0;
      refDue_reg   <= 1'b0;
    end else if (clockEnable) begin
      if (refTimer_reg >= ROW_INTERVAL - 1) begin
        refTimer_reg <= 32'h0;
        refDue_reg   <= 1'b1;
      end else begin
        refTimer_reg <= refTimer_reg + 32'h1;
        if (state_reg == ST_REFR && cycDone) refDue_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= ST_PWRUP;
      retState_reg   <= ST_IDLE;
      wait_reg       <= 32'h0;
      row_reg        <= 11'h000;
      col_reg        <= 11'h000;
      testCol_reg    <= 11'h000;
      pattern_reg    <= 8'h00;
      pass_reg       <= 1'b0;
      count_reg      <= 11'h000;
      start_reg      <= 1'b0;
      kind_reg       <= CY_CBR;
      wdata_reg      <= 8'h00;
      cycPending_reg <= 1'b0;
      checkRead_reg  <= 1'b0;
      ready          <= 1'b0;
      testBusy       <= 1'b0;
      testDone       <= 1'b0;
      testFail       <= 1'b0;
      failRow        <= 11'h000;
      failCol        <= 11'h000;
    end else if (clockEnable) begin
      start_reg <= 1'b0;
      testDone  <= 1'b0;
      if (cycDone && checkRead_reg && rdData != wdata_reg && !testFail) begin
        testFail <= 1'b1;
        failRow  <= (kind_reg == CY_CBR_RD) ? count_reg : row_reg;
        failCol  <= col_reg;
      end
      if (cycDone) cycPending_reg <= 1'b0;
      case (state_reg)
        ST_PWRUP: begin
          if (wait_reg >= POWERUP_WAIT - 1) begin
            wait_reg  <= 32'h0;
            state_reg <= ST_INIT;
          end else wait_reg <= wait_reg + 32'h1;
        end
        ST_INIT: begin
          // Column-first cycles also strobe the row, covering wake-up and counter init
          if (!busy && !cycPending_reg && !start_reg) begin
            if (count_reg == 11'(INIT_CYCLES)) begin
              count_reg <= 11'h000;
              ready     <= 1'b1;
              state_reg <= ST_IDLE;
            end else begin
              kind_reg  <= CY_CBR;
              start_reg <= 1'b1;
              cycPending_reg <= 1'b1;
              count_reg <= count_reg + 11'h001;
            end
          end
        end
        ST_IDLE: begin
          if (refDue_reg) begin
            retState_reg <= ST_IDLE;
            state_reg    <= ST_REFR;
          end else if (testStart) begin
            testBusy    <= 1'b1;
            testFail    <= 1'b0;
            testCol_reg <= testColumn;
            pattern_reg <= 8'h00;
            pass_reg    <= 1'b0;
            row_reg     <= 11'h000;
            col_reg     <= 11'h000;
            state_reg   <= ST_FILL;
          end
        end
        ST_REFR: begin
          if (!busy && !cycPending_reg && !start_reg && refDue_reg) begin
            kind_reg  <= CY_CBR;
            // Refresh carries no data; a stale read flag would fail it
            checkRead_reg <= 1'b0;
            start_reg <= 1'b1;
            cycPending_reg <= 1'b1;
          end else if (cycDone) state_reg <= retState_reg;
        end
        default: begin
          // No column-first refresh in counter steps: it would step the device
          // counter and skip a row; each counter-test cycle refreshes a row
          if (refDue_reg && !busy && !cycPending_reg && !start_reg &&
              state_reg != ST_CNTREAD && state_reg != ST_CNTWR) begin
            retState_reg <= state_reg;
            state_reg    <= ST_REFR;
          end else if (!busy && !cycPending_reg && !start_reg) begin
            case (state_reg)
              ST_FILL: begin
                kind_reg  <= CY_NORMAL_WR;
                wdata_reg <= pattern_reg;
                checkRead_reg <= 1'b0;
                if (col_reg == 11'(FILL_COLS - 1)) begin
                  col_reg <= 11'h000;
                  if (row_reg == 11'(FILL_ROWS - 1)) begin
                    row_reg   <= 11'h000;
                    count_reg <= 11'h000;
                    state_reg <= ST_CNTREAD;
                  end else row_reg <= row_reg + 11'h001;
                end else col_reg <= col_reg + 11'h001;
                start_reg <= 1'b1;
                cycPending_reg <= 1'b1;
              end
              ST_CNTREAD: begin
                col_reg   <= testCol_reg;
                kind_reg  <= CY_CBR_RD;
                wdata_reg <= pattern_reg;
                checkRead_reg <= 1'b1;
                start_reg <= 1'b1;
                cycPending_reg <= 1'b1;
                if (count_reg == 11'(TEST_ROWS - 1)) begin
                  count_reg <= 11'h000;
                  state_reg <= ST_CNTWR;
                end else count_reg <= count_reg + 11'h001;
              end
              ST_CNTWR: begin
                kind_reg  <= CY_CBR_WR;
                wdata_reg <= ~pattern_reg;
                checkRead_reg <= 1'b0;
                start_reg <= 1'b1;
                cycPending_reg <= 1'b1;
                if (count_reg == 11'(TEST_ROWS - 1)) begin
                  count_reg <= 11'h000;
                  // One below row zero: the check step advances before each read
                  row_reg   <= 11'h7FF;
                  state_reg <= ST_CHECK;
                end else count_reg <= count_reg + 11'h001;
              end
              ST_CHECK: begin
                kind_reg  <= CY_NORMAL_RD;
                wdata_reg <= ~pattern_reg;
                checkRead_reg <= 1'b1;
                start_reg <= 1'b1;
                cycPending_reg <= 1'b1;
                if (row_reg == 11'(TEST_ROWS - 2)) state_reg <= ST_DONE;
                row_reg <= row_reg + 11'h001;
              end
              ST_DONE: begin
                checkRead_reg <= 1'b0;
                if (!pass_reg) begin
                  pass_reg    <= 1'b1;
                  pattern_reg <= 8'hFF;
                  row_reg     <= 11'h000;
                  col_reg     <= 11'h000;
                  state_reg   <= ST_FILL;
                end else begin
                  testBusy  <= 1'b0;
                  testDone  <= 1'b1;
                  state_reg <= ST_IDLE;
                end
              end
              default: state_reg <= ST_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  drct_strobe_gen u_strobe (
    .clock         (clock),
    .rst_n         (rst_n),
    .clockEnable   (clockEnable),
    .start         (start_reg),
    .cycleKind     (kind_reg),
    .rowAddr       (row_reg),
    .colAddr       (col_reg),
    .wrData        (wdata_reg),
    .dataLinesIn   (dinS2_reg),
    .busy          (busy),
    .done          (cycDone),
    .rdData        (rdData),
    .rowStrobe_n   (rowStrobe_n),
    .colStrobe_n   (colStrobe_n),
    .writeStrobe_n (writeStrobe_n),
    .addressInputs (addressInputs),
    .dataLinesOut  (dataLinesOut),
    .dataLinesOe_n (dataLinesOe_n)
  );

  initcnt_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(ready) |-> $past(count_reg) == 11'(INIT_CYCLES))
    else $error("too few init cycles");
  cntstep_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == ST_CNTREAD && $past(state_reg) != ST_CNTREAD) |-> count_reg == 11'h000)
    else $error("counter step not from zero");
  failflag_a: assert property (@(posedge clock) disable iff (!rst_n)
    (clockEnable && cycDone && checkRead_reg && rdData != wdata_reg) |=> testFail)
    else $error("mismatch not flagged");
  invpass_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(pass_reg) |-> pattern_reg == 8'hFF)
    else $error("second pass not inverted");
  cbrcol_a: assert property (@(posedge clock) disable iff (!rst_n)
    (start_reg && kind_reg == CY_CBR_WR) |-> col_reg == testCol_reg)
    else $error("counter write column moved");
endmodule

/* verif/drct_dram_model.sv */
`timescale 1ns/1ps
// Behavioural memory array; it has no clock and acts on strobe edges only.
module drct_dram_model
  import drct_pkg::*;
#(
  parameter int unsigned CNT_ROWS = ROWS
)(
  input  wire logic              rowStrobe_n,
  input  wire logic              colStrobe_n,
  input  wire logic              writeStrobe_n,
  input  wire logic [ADDR_W-1:0] addressInputs,
  input  wire logic [DATA_W-1:0] dataLines,
  input  wire logic              faultEn,
  output logic [DATA_W-1:0]      devData,
  output int                     cntRd,
  output int                     cntWr,
  output int                     normWr
);
  // Sparse store; unwritten cells read as zero so a shortened fill still works
  logic [DATA_W-1:0]   mem [logic [2*ADDR_W-1:0]];
  int unsigned         counter_reg = 0;
  logic [ADDR_W-1:0]   rowAddr_reg = '0;
  logic [2*ADDR_W-1:0] key;
  logic                cbr_reg     = 1'b0;
  logic                readOn_reg  = 1'b0;
  logic [DATA_W-1:0]   rdVal_reg   = '0;
  logic [DATA_W-1:0]   lastVal_reg = '0;

  initial begin
    cntRd = 0;
    cntWr = 0;
    normWr = 0;
  end

  always @(negedge rowStrobe_n) begin
    if (colStrobe_n === 1'b0) begin
      cbr_reg = 1'b1;
      rowAddr_reg = ADDR_W'(counter_reg);
      counter_reg = (counter_reg + 1) % CNT_ROWS;
    end else begin
      cbr_reg = 1'b0;
      rowAddr_reg = addressInputs;
    end
  end

  always @(negedge colStrobe_n) begin
    if (rowStrobe_n === 1'b0) begin
      key = {rowAddr_reg, addressInputs};
      if (writeStrobe_n === 1'b0) begin
        mem[key] = dataLines;
        if (cbr_reg) cntWr++;
        else normWr++;
      end else begin
        rdVal_reg = mem.exists(key) ? mem[key] : '0;
        readOn_reg = 1'b1;
        if (cbr_reg) cntRd++;
      end
    end
  end

  // Output follows the column strobe, then shows a changed value, not the old one
  always @(posedge colStrobe_n) begin
    if (readOn_reg) begin
      lastVal_reg = rdVal_reg;
      readOn_reg = 1'b0;
    end
  end

  assign devData = readOn_reg ? (rdVal_reg ^ {{(DATA_W-1){1'b0}}, faultEn})
                              : ~lastVal_reg;
endmodule

/* verif/drct_refresh_tester_tb.sv */
`timescale 1ns/1ps
module drct_refresh_tester_tb
  import drct_pkg::*;
;
  localparam int unsigned ROW_IV = 200;
  localparam int unsigned FR     = 4;
  localparam int unsigned FC     = 2;
  // Rows under counter test, shortened to keep the run short
  localparam int unsigned TR     = 64;

  logic              clock;
  logic              arst_n;
  logic              clockEnable;
  logic              testStart;
  logic [ADDR_W-1:0] testColumn;
  logic [DATA_W-1:0] dataLinesIn;
  logic              rowStrobe_n;
  logic              colStrobe_n;
  logic              writeStrobe_n;
  logic [ADDR_W-1:0] addressInputs;
  logic [DATA_W-1:0] dataLinesOut;
  logic              dataLinesOe_n;
  logic              ready;
  logic              testBusy;
  logic              testDone;
  logic              testFail;
  logic [ADDR_W-1:0] failRow;
  logic [ADDR_W-1:0] failCol;
  logic [DATA_W-1:0] devData;
  logic              faultEn;
  int                cntRd;
  int                cntWr;
  int                normWr;
  int                badCount = 0;
  int                compares = 0;
  int                rasBeforeReady = 0;
  realtime           rasFallT = 0;
  realtime           lastCbrT = 0;
  realtime           firstRasT = 0;
  realtime           relT = 0;
  realtime           maxRas = 0;
  realtime           maxGap = 0;

  drct_refresh_tester #(.POWERUP_WAIT(20), .ROW_INTERVAL(ROW_IV), .FILL_ROWS(FR),
                        .FILL_COLS(FC), .TEST_ROWS(TR)) i_dut (
    .clock(clock), .arst_n(arst_n), .clockEnable(clockEnable), .testStart(testStart),
    .testColumn(testColumn), .dataLinesIn(dataLinesIn), .rowStrobe_n(rowStrobe_n),
    .colStrobe_n(colStrobe_n), .writeStrobe_n(writeStrobe_n),
    .addressInputs(addressInputs), .dataLinesOut(dataLinesOut),
    .dataLinesOe_n(dataLinesOe_n), .ready(ready), .testBusy(testBusy),
    .testDone(testDone), .testFail(testFail), .failRow(failRow), .failCol(failCol));

  drct_dram_model #(.CNT_ROWS(TR)) i_mem (
    .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n), .writeStrobe_n(writeStrobe_n),
    .addressInputs(addressInputs), .dataLines(dataLinesIn), .faultEn(faultEn),
    .devData(devData), .cntRd(cntRd), .cntWr(cntWr), .normWr(normWr));

  // Shared data lines: the controller wins only while it enables its driver
  assign dataLinesIn = (dataLinesOe_n === 1'b0) ? dataLinesOut : devData;

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(negedge rowStrobe_n) begin
    rasFallT = $realtime;
    if (firstRasT == 0) firstRasT = $realtime;
    if (ready !== 1'b1) rasBeforeReady++;
    if (colStrobe_n === 1'b0 && ready === 1'b1) begin
      if (lastCbrT > 0 && $realtime - lastCbrT > maxGap) maxGap = $realtime - lastCbrT;
      lastCbrT = $realtime;
    end
  end

  always @(posedge rowStrobe_n) begin
    if ($realtime - rasFallT > maxRas) maxRas = $realtime - rasFallT;
  end

  task automatic cmpBit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cmpVec(input string what, input logic [ADDR_W-1:0] exp,
                        input logic [ADDR_W-1:0] got);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmpNum(input string what, input int exp, input int got);
    compares++;
    if (got != exp) begin
      badCount++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic giveVerdict();
    $display("Comparisons %0d, mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic checkResetState(input string name);
    cmpBit("row strobe idle", 1'b1, rowStrobe_n);
    cmpBit("column strobe idle", 1'b1, colStrobe_n);
    cmpBit("write strobe idle", 1'b1, writeStrobe_n);
    cmpBit("data driver off", 1'b1, dataLinesOe_n);
    cmpBit("ready cleared", 1'b0, ready);
    cmpBit("busy cleared", 1'b0, testBusy);
    cmpBit("fail cleared", 1'b0, testFail);
    cmpVec("address cleared", '0, addressInputs);
    $display("Test %s finished", name);
  endtask

  task automatic startTest();
    @(negedge clock) testStart = 1'b1;
    for (int n = 0; n < 200 && testBusy !== 1'b1; n++) @(negedge clock);
    testStart = 1'b0;
    cmpBit("busy after start", 1'b1, testBusy);
  endtask

  task automatic testEarlyStart();
    @(negedge clock) testStart = 1'b1;
    repeat (5) @(negedge clock);
    testStart = 1'b0;
    for (int n = 0; n < 5000 && ready !== 1'b1; n++) @(negedge clock);
    cmpBit("ready after init", 1'b1, ready);
    repeat (20) @(negedge clock);
    cmpBit("start before ready refused", 1'b0, testBusy);
    cmpBit("init row cycles", 1'b1, rasBeforeReady >= INIT_CYCLES);
    cmpBit("power-up pause", 1'b1, firstRasT - relT >= 20 * 8.0);
    $display("Test early start finished");
  endtask

  task automatic testFullRun();
    logic [13:0] snap;
    startTest();
    repeat (100) @(negedge clock);
    clockEnable = 1'b0;
    snap = {rowStrobe_n, colStrobe_n, writeStrobe_n, addressInputs};
    repeat (40) @(negedge clock);
    cmpBit("frozen outputs", 1'b1,
           snap === {rowStrobe_n, colStrobe_n, writeStrobe_n, addressInputs});
    clockEnable = 1'b1;
    for (int n = 0; n < 40000 && testDone !== 1'b1; n++) @(negedge clock);
    cmpBit("done pulse", 1'b1, testDone);
    cmpBit("clean run no fail", 1'b0, testFail);
    @(negedge clock);
    cmpBit("done lasts one cycle", 1'b0, testDone);
    cmpBit("idle after done", 1'b0, testBusy);
    cmpNum("counter reads", 2 * TR, cntRd);
    cmpNum("counter writes", 2 * TR, cntWr);
    cmpNum("fill writes", 2 * FR * FC, normWr);
    cmpBit("row active limit", 1'b1, maxRas <= ROW_ACTIVE_US * 1000.0);
    cmpBit("refresh spacing", 1'b1, maxGap <= 2 * ROW_IV * 8.0);
    $display("Test full run finished");
  endtask

  task automatic testFault();
    faultEn = 1'b1;
    testColumn = 11'h155;
    startTest();
    for (int n = 0; n < 20000 && testFail !== 1'b1; n++) @(negedge clock);
    cmpBit("fail flag raised", 1'b1, testFail);
    cmpVec("fail column", 11'h155, failCol);
    // First counter read fails; row is reported as steps taken
    cmpVec("fail row", 11'h001, failRow);
    repeat (10) @(negedge clock);
    testStart = 1'b1;
    repeat (3) @(negedge clock);
    testStart = 1'b0;
    repeat (10) @(negedge clock);
    cmpBit("restart while busy refused", 1'b1, testFail);
    cmpBit("still busy", 1'b1, testBusy);
    $display("Test fault finished");
    arst_n = 1'b0;
    #1;
    checkResetState("mid-run reset");
    faultEn = 1'b0;
    @(negedge clock) arst_n = 1'b1;
    repeat (2) @(negedge clock);
    checkResetState("after mid-run release");
  endtask

  initial begin
    #(60000 * 8);
    badCount++;
    $display("Error watchdog expected finish seen timeout");
    giveVerdict();
  end

  initial begin
    clockEnable = 1'b1;
    testStart = 1'b0;
    testColumn = 11'h7FF;
    faultEn = 1'b0;
    arst_n = 1'b0;
    repeat (3) @(posedge clock);
    checkResetState("power-on");
    @(negedge clock) arst_n = 1'b1;
    relT = $realtime;
    testEarlyStart();
    testFullRun();
    testFault();
    giveVerdict();
  end
endmodule
